/* File: hdl/dcldma_defs.svh */
// Register offsets, field positions, reset values and ports of the DMA block
`ifndef DCLDMA_DEFS_SVH
`define DCLDMA_DEFS_SVH

// Register index within a controller
`define DCL_OFF_STATUS 4'h8
`define DCL_OFF_REQ 4'h9
`define DCL_OFF_SMASK 4'ha
`define DCL_OFF_MODE 4'hb
`define DCL_OFF_CLRBP 4'hc
`define DCL_OFF_MCLR 4'hd
`define DCL_OFF_CLRMASK 4'he
`define DCL_OFF_AMASK 4'hf
// Second controller: word ports from 0xc0, index times two
`define DCL_C2_HI 3'h6
// Page register ports per channel
`define DCL_PAGE_CH0 8'h87
`define DCL_PAGE_CH1 8'h83
`define DCL_PAGE_CH2 8'h81
`define DCL_PAGE_CH3 8'h82
`define DCL_PAGE_CH4 8'h8f
`define DCL_PAGE_CH5 8'h8b
`define DCL_PAGE_CH6 8'h89
`define DCL_PAGE_CH7 8'h8a
// Field positions
`define DCL_CMD_ROT 4
`define DCL_CMD_DIS 2
`define DCL_WR_BIT 2
`define DCL_MODE_DEC 3
`define DCL_MODE_AUTO 2
// Reset values
`define DCL_CMD_RST 8'h00
`define DCL_MODE_RST 6'h00
`define DCL_MASK_RST 4'hf
`define DCL_CNT_TC 16'h0000

`endif

/* File: hdl/dcldma_pkg.sv */
// Types shared by the DMA block
package dcldma_pkg;
    typedef enum logic [1:0] {
        DCL_DEMAND = 2'b00,
        DCL_SINGLE = 2'b01,
        DCL_BLOCK = 2'b10,
        DCL_CASCADE = 2'b11
    } dcl_xmode_t;
    typedef enum logic [1:0] {
        DCL_VERIFY = 2'b00,
        DCL_WRITE = 2'b01,
        DCL_READ = 2'b10,
        DCL_ILLEGAL = 2'b11
    } dcl_xtype_t;
endpackage

/* File: hdl/dcldma_top.sv */
// Cascaded two-controller DMA engine with its transfer FIFO
// Notes on behaviour
// - Command bit 4: one rotating priority, zero fixed priority.
// - Command bit 2 set disables every channel of that controller.
// - Mode bits 7:6: demand, single, block, cascade.
// - Mode bit 5: zero increments address, one decrements.
// - Mode bit 4 enables reload of working registers at terminal count.
// - Mode bits 3:2 give transfer type; ignored in cascade mode.
// - Six-bit mode per channel; bits 1:0 of writes pick the channel.
// - Request bit 2 sets software request; unmasked but prioritized; block mode (the code uses the channel's programmed mode bits instead).
// - Terminal count clears the channel's software request.
// - Status shows pending requests in 7:4, terminal-count flags in 3:0.
// - Terminal count sets the mask bit unless auto-initialization is on.
// - Single-mask write bit 2 masks or unmasks the selected channel.
// - All-mask register holds four mask bits, resets to 1111.
// - Masking channel 4 blocks every request of the first controller.
// - Current address steps per transfer; base reloads only at terminal count.
// - Transfer address is page in 23:16 and address in 15:0 on channels 0-3.
// - Address and count move as two bytes chosen by a byte pointer.
// - One more transfer than count; terminal count on 0 to FFFFh.
// - Channels 0-3 count bytes; 5-7 count words with shifted address.
// - Clear-byte-pointer write, reset and master clear reset the pointer.
// - Master-clear write resets the controller like hardware reset.
// - Clear-mask write unmasks all four channels of that controller.
// - Second controller's channel 4 request status shows any pending first-controller request.
// - Command is write-only at the status port, resets to zero.
`timescale 1ns/1ps
`include "dcldma_defs.svh"

module dcldma_fifo #(
    parameter int WIDTH = 30,
    parameter int DEPTH = 16
) (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW:0] wr_ptr_r;
    logic [AW:0] rd_ptr_r;
    logic full;
    logic empty;

    assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                  (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
    assign empty = (wr_ptr_r == rd_ptr_r);
    assign in_ready_o = !full;
    assign out_valid_o = !empty;
    assign out_data_o = mem_r[rd_ptr_r[AW-1:0]];

    always_ff @(posedge clk_sys_i) begin
        if (in_valid_i && !full) begin
            mem_r[wr_ptr_r[AW-1:0]] <= in_data_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else begin
            if (in_valid_i && !full) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (out_ready_i && !empty) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end
endmodule // dcldma_fifo

module dcldma_top
    import dcldma_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic cpu_reset_i,
    input wire logic [7:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [7:0] io_wdata_i,
    output logic [7:0] io_rdata_o,
    output logic io_rvalid_o,
    input wire logic [7:0] channel_request_line_i,
    output logic [7:0] channel_acknowledge_line_o,
    output logic [7:0] terminal_count_o,
    output logic xfer_valid_o,
    input wire logic xfer_ready_i,
    output logic [23:0] xfer_addr_o,
    output logic [1:0] xfer_type_o,
    output logic [2:0] xfer_chan_o,
    output logic xfer_last_o
);
    logic [15:0] base_addr_r [8];
    logic [15:0] cur_addr_r [8];
    logic [15:0] base_cnt_r [8];
    logic [15:0] cur_cnt_r [8];
    logic [7:0] page_r [8];
    logic [5:0] mode_r [8];
    logic [7:0] mask_r;
    logic [7:0] swreq_r;
    logic [7:0] tc_r;
    logic [7:0] cmd_r [2];
    logic [1:0] bptr_r;
    logic [1:0] rot_r [2];
    logic lock_r;
    logic [2:0] lock_ch_r;

    // Address decode
    logic dec_hit;
    logic dec_ctl;
    logic [3:0] dec_off;
    logic dec_page;
    logic [2:0] dec_pch;
    logic [7:0] page_port [8];
    assign page_port = '{`DCL_PAGE_CH0, `DCL_PAGE_CH1, `DCL_PAGE_CH2,
        `DCL_PAGE_CH3, `DCL_PAGE_CH4, `DCL_PAGE_CH5, `DCL_PAGE_CH6,
        `DCL_PAGE_CH7};

    always_comb begin
        dec_hit = 1'b0;
        dec_ctl = 1'b0;
        dec_off = 4'h0;
        dec_page = 1'b0;
        dec_pch = 3'h0;
        if (io_addr_i[7:4] == 4'h0) begin
            dec_hit = 1'b1;
            dec_off = io_addr_i[3:0];
        end else if (io_addr_i[7:5] == `DCL_C2_HI && !io_addr_i[0]) begin
            dec_hit = 1'b1;
            dec_ctl = 1'b1;
            dec_off = io_addr_i[4:1];
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (io_addr_i == page_port[i]) begin
                    dec_page = 1'b1;
                    dec_pch = 3'(i);
                end
            end
        end
    end

    logic wr_hit;
    logic rd_hit;
    logic is_chreg;
    logic [2:0] reg_ch;
    logic [1:0] mclr;
    assign wr_hit = io_wr_i && dec_hit;
    assign rd_hit = io_rd_i && dec_hit;
    assign is_chreg = !dec_off[3];
    assign reg_ch = {dec_ctl, dec_off[2:1]};
    assign mclr[0] = cpu_reset_i ||
        (wr_hit && !dec_ctl && dec_off == `DCL_OFF_MCLR);
    assign mclr[1] = cpu_reset_i ||
        (wr_hit && dec_ctl && dec_off == `DCL_OFF_MCLR);

    function automatic logic [2:0] arb4(input logic [3:0] req,
                                        input logic rot,
                                        input logic [1:0] last);
        logic [2:0] res;
        logic [1:0] idx;
        res = 3'b000;
        for (int i = 3; i >= 0; i--) begin
            idx = rot ? 2'(last + 2'(i) + 2'd1) : 2'(i);
            if (req[idx]) begin
                res = {1'b1, idx};
            end
        end
        return res;
    endfunction

    // Request eligibility and arbitration
    logic [1:0] dis;
    logic [7:0] pend;
    logic [7:0] live;
    logic [7:0] elig;
    logic [7:0] casc_ack;
    logic [2:0] win1;
    logic [2:0] win2;
    logic go;
    logic [2:0] g;
    logic tc_hit;
    logic fifo_in_ready;
    assign dis[0] = cmd_r[0][`DCL_CMD_DIS] | cmd_r[1][`DCL_CMD_DIS];
    assign dis[1] = cmd_r[1][`DCL_CMD_DIS];
    assign pend = channel_request_line_i | swreq_r;

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            // Software requests bypass the mask
            live[i] = (channel_request_line_i[i] & ~mask_r[i]) | swreq_r[i];
            if (i < 4) begin
                live[i] = live[i] & ~mask_r[4] & ~dis[0];
            end else begin
                live[i] = live[i] & ~dis[1];
            end
            elig[i] = live[i] && (mode_r[i][5:4] != DCL_CASCADE);
            casc_ack[i] = live[i] && (mode_r[i][5:4] == DCL_CASCADE);
        end
        elig[4] = 1'b0;
        casc_ack[4] = 1'b0;
    end

    assign win1 = arb4(elig[3:0], cmd_r[0][`DCL_CMD_ROT], rot_r[0]);
    assign win2 = arb4({elig[7:5], win1[2]}, cmd_r[1][`DCL_CMD_ROT],
                       rot_r[1]);

    always_comb begin
        if (lock_r) begin
            g = lock_ch_r;
            go = fifo_in_ready && !dis[lock_ch_r[2]] &&
                 !(lock_ch_r[2] == 1'b0 && mask_r[4]);
        end else begin
            g = (win2[1:0] == 2'd0) ? {1'b0, win1[1:0]} : {1'b1, win2[1:0]};
            go = fifo_in_ready && win2[2];
        end
    end

    assign tc_hit = (cur_cnt_r[g] == `DCL_CNT_TC);

    // Transfer descriptor
    logic [23:0] xaddr;
    logic [1:0] xtype;
    logic [29:0] push_data;
    logic [29:0] pop_data;
    always_comb begin
        if (g[2]) begin
            xaddr = {page_r[g][7:1], cur_addr_r[g], 1'b0};
        end else begin
            xaddr = {page_r[g], cur_addr_r[g]};
        end
        xtype = mode_r[g][1:0];
    end
    assign push_data = {g, xtype, tc_hit, xaddr};

    dcldma_fifo #(
        .WIDTH(30),
        .DEPTH(FIFO_DEPTH)
    ) dcldma_fifo_inst (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .in_valid_i(go),
        .in_ready_o(fifo_in_ready),
        .in_data_i(push_data),
        .out_valid_o(xfer_valid_o),
        .out_ready_i(xfer_ready_i),
        .out_data_o(pop_data)
    );
    assign xfer_chan_o = pop_data[29:27];
    assign xfer_type_o = pop_data[26:25];
    assign xfer_last_o = pop_data[24];
    assign xfer_addr_o = pop_data[23:0];

    // Channel address, count and page
    always_ff @(posedge clk_sys_i) begin
        if (wr_hit && is_chreg) begin
            if (!dec_off[0]) begin
                if (bptr_r[dec_ctl]) begin
                    base_addr_r[reg_ch][15:8] <= io_wdata_i;
                    cur_addr_r[reg_ch][15:8] <= io_wdata_i;
                end else begin
                    base_addr_r[reg_ch][7:0] <= io_wdata_i;
                    cur_addr_r[reg_ch][7:0] <= io_wdata_i;
                end
            end else begin
                if (bptr_r[dec_ctl]) begin
                    base_cnt_r[reg_ch][15:8] <= io_wdata_i;
                    cur_cnt_r[reg_ch][15:8] <= io_wdata_i;
                end else begin
                    base_cnt_r[reg_ch][7:0] <= io_wdata_i;
                    cur_cnt_r[reg_ch][7:0] <= io_wdata_i;
                end
            end
        end else if (go) begin
            if (tc_hit && mode_r[g][`DCL_MODE_AUTO]) begin
                cur_addr_r[g] <= base_addr_r[g];
                cur_cnt_r[g] <= base_cnt_r[g];
            end else begin
                // Wraps to ffff without reload and keeps counting down on later transfers
                cur_cnt_r[g] <= cur_cnt_r[g] - 16'h0001;
                if (mode_r[g][`DCL_MODE_DEC]) begin
                    cur_addr_r[g] <= cur_addr_r[g] - 16'h0001;
                end else begin
                    cur_addr_r[g] <= cur_addr_r[g] + 16'h0001;
                end
            end
        end
        if (io_wr_i && dec_page) begin
            page_r[dec_pch] <= io_wdata_i;
        end
    end

    // Mode registers
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < 8; i++) begin
                mode_r[i] <= `DCL_MODE_RST;
            end
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (mclr[i/4]) begin
                    mode_r[i] <= `DCL_MODE_RST;
                end
            end
            if (wr_hit && dec_off == `DCL_OFF_MODE) begin
                mode_r[{dec_ctl, io_wdata_i[1:0]}] <= io_wdata_i[7:2];
            end
        end
    end

    // Command, byte pointer and rotation
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cmd_r[0] <= `DCL_CMD_RST;
            cmd_r[1] <= `DCL_CMD_RST;
            bptr_r <= 2'b00;
            rot_r[0] <= 2'd3;
            rot_r[1] <= 2'd3;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (mclr[c]) begin
                    cmd_r[c] <= `DCL_CMD_RST;
                    bptr_r[c] <= 1'b0;
                    rot_r[c] <= 2'd3;
                end
            end
            if (wr_hit && dec_off == `DCL_OFF_STATUS) begin
                cmd_r[dec_ctl] <= io_wdata_i;
            end
            if (wr_hit && dec_off == `DCL_OFF_CLRBP) begin
                bptr_r[dec_ctl] <= 1'b0;
            end else if ((wr_hit || rd_hit) && is_chreg) begin
                bptr_r[dec_ctl] <= ~bptr_r[dec_ctl];
            end
            if (go && !lock_r) begin
                if (g[2]) begin
                    rot_r[1] <= g[1:0];
                end else begin
                    rot_r[0] <= g[1:0];
                    rot_r[1] <= 2'd0;
                end
            end
        end
    end

    // Masks, software requests and terminal-count flags
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mask_r <= {`DCL_MASK_RST, `DCL_MASK_RST};
            swreq_r <= 8'h00;
            tc_r <= 8'h00;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (mclr[c]) begin
                    mask_r[c*4 +: 4] <= `DCL_MASK_RST;
                    swreq_r[c*4 +: 4] <= 4'h0;
                    tc_r[c*4 +: 4] <= 4'h0;
                end
            end
            if (wr_hit) begin
                if (dec_off == `DCL_OFF_REQ) begin
                    swreq_r[{dec_ctl, io_wdata_i[1:0]}] <=
                        io_wdata_i[`DCL_WR_BIT];
                end else if (dec_off == `DCL_OFF_SMASK) begin
                    mask_r[{dec_ctl, io_wdata_i[1:0]}] <=
                        io_wdata_i[`DCL_WR_BIT];
                end else if (dec_off == `DCL_OFF_AMASK) begin
                    mask_r[dec_ctl*4 +: 4] <= io_wdata_i[3:0];
                end else if (dec_off == `DCL_OFF_CLRMASK) begin
                    mask_r[dec_ctl*4 +: 4] <= 4'h0;
                end
            end
            if (rd_hit && dec_off == `DCL_OFF_STATUS) begin
                tc_r[dec_ctl*4 +: 4] <= 4'h0;
            end
            // Set after clear so a same-cycle event is kept
            if (go && tc_hit) begin
                tc_r[g] <= 1'b1;
                swreq_r[g] <= 1'b0;
                if (!mode_r[g][`DCL_MODE_AUTO]) begin
                    mask_r[g] <= 1'b1;
                end
            end
        end
    end

    // Block mode holds the bus until terminal count
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lock_r <= 1'b0;
            lock_ch_r <= 3'h0;
        end else if (mclr[0] || mclr[1]) begin
            lock_r <= 1'b0;
        end else if (go) begin
            lock_r <= !tc_hit && (mode_r[g][5:4] == DCL_BLOCK);
            lock_ch_r <= g;
        end else if (lock_r && dis[lock_ch_r[2]]) begin
            lock_r <= 1'b0;
        end
    end

    // Acknowledge and terminal-count strobes
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            channel_acknowledge_line_o <= 8'h00;
            terminal_count_o <= 8'h00;
        end else begin
            channel_acknowledge_line_o <= casc_ack |
                (go ? (8'h01 << g) : 8'h00);
            terminal_count_o <= (go && tc_hit) ? (8'h01 << g) : 8'h00;
        end
    end

    // Register read back
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            io_rdata_o <= 8'h00;
            io_rvalid_o <= 1'b0;
        end else begin
            io_rvalid_o <= io_rd_i;
            io_rdata_o <= 8'h00;
            if (io_rd_i && dec_page) begin
                io_rdata_o <= page_r[dec_pch];
            end else if (rd_hit) begin
                if (is_chreg && !dec_off[0]) begin
                    io_rdata_o <= bptr_r[dec_ctl] ?
                        cur_addr_r[reg_ch][15:8] : cur_addr_r[reg_ch][7:0];
                end else if (is_chreg) begin
                    io_rdata_o <= bptr_r[dec_ctl] ?
                        cur_cnt_r[reg_ch][15:8] : cur_cnt_r[reg_ch][7:0];
                end else if (dec_off == `DCL_OFF_STATUS) begin
                    // Channel 4 slot shows first-controller activity
                    io_rdata_o <= dec_ctl ?
                        {pend[7:5], |pend[3:0], tc_r[7:4]} :
                        {pend[3:0], tc_r[3:0]};
                end else if (dec_off == `DCL_OFF_AMASK) begin
                    io_rdata_o <= {4'h0, mask_r[dec_ctl*4 +: 4]};
                end
            end
        end
    end
endmodule // dcldma_top

/* File: tb/dcldma_monitor.sv */
// Port checker for the cascaded DMA block
`timescale 1ns/1ps
module dcldma_monitor #(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic cpu_reset_i,
    input wire logic [7:0] io_addr_i,
    input wire logic io_wr_i,
    input wire logic io_rd_i,
    input wire logic [7:0] io_wdata_i,
    input wire logic [7:0] io_rdata_o,
    input wire logic io_rvalid_o,
    input wire logic [7:0] channel_acknowledge_line_o,
    input wire logic [7:0] terminal_count_o,
    input wire logic xfer_valid_o,
    input wire logic xfer_ready_i,
    input wire logic [23:0] xfer_addr_o,
    input wire logic [2:0] xfer_chan_o
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!arst_n_i);

    a_read_answer: assert property (io_rd_i |=> io_rvalid_o)
        else $error("read not answered next cycle");
    a_wo_zero: assert property (io_rd_i && io_addr_i == 8'h0b
        |=> io_rdata_o == 8'h00)
        else $error("write-only port read nonzero");
    a_tc_onehot: assert property ($onehot0(terminal_count_o))
        else $error("terminal count on several channels");
    a_tc_on_xfer: assert property (terminal_count_o != 8'h00
        |-> (channel_acknowledge_line_o & terminal_count_o)
        == terminal_count_o)
        else $error("terminal count without transfer");
    a_no_chan_four: assert property (xfer_valid_o
        |-> xfer_chan_o != 3'h4 && !terminal_count_o[4])
        else $error("transfer on cascade channel");
    // Master clear may not flush the FIFO, so writes are excluded
    a_hold_desc: assert property (xfer_valid_o && !xfer_ready_i
        && !cpu_reset_i && !io_wr_i |=> xfer_valid_o
        && $stable(xfer_addr_o) && $stable(xfer_chan_o))
        else $error("descriptor changed before pop");
    a_mclr_masks: assert property ((cpu_reset_i || io_wr_i
        && io_addr_i == 8'h0d) ##2 io_rd_i && io_addr_i == 8'h0f
        |=> io_rdata_o[3:0] == 4'hf)
        else $error("masks not set by master clear");
    a_status_clear: assert property (io_rd_i && io_addr_i == 8'h08
        ##1 (terminal_count_o[3:0] == 4'h0) [*2]
        ##0 io_rd_i && io_addr_i == 8'h08 |=> io_rdata_o[3:0] == 4'h0)
        else $error("status flags not cleared by read");
    a_group_off: assert property (io_wr_i && io_addr_i == 8'hd0
        && io_wdata_i[2] |=> ##2 (terminal_count_o == 8'h00) [*4])
        else $error("transfers while group disabled");
endmodule // dcldma_monitor

bind dcldma_top dcldma_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) dcldma_monitor_inst (
    .clk_sys_i, .arst_n_i, .cpu_reset_i, .io_addr_i, .io_wr_i, .io_rd_i,
    .io_wdata_i, .io_rdata_o, .io_rvalid_o, .channel_acknowledge_line_o,
    .terminal_count_o, .xfer_valid_o, .xfer_ready_i, .xfer_addr_o,
    .xfer_chan_o);

/* File: tb/dcldma_sink.sv */
// Descriptor consumer model with stall and slow modes
`timescale 1ns/1ps
module dcldma_sink (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic stall_i,
    input wire logic slow_i,
    output logic ready_o
);
    logic phase_r;
    // Slow mode takes every other cycle, so the FIFO sees backpressure
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            phase_r <= 1'b0;
        end else begin
            phase_r <= ~phase_r;
        end
    end
    assign ready_o = !stall_i && (!slow_i || phase_r);
endmodule // dcldma_sink

/* File: tb/dcldma_top_test.sv */
// Self-checking bench for the cascaded DMA block
`timescale 1ns/1ps
module dcldma_top_test;
    logic clk_sys_i, arst_n_i, cpu_reset_i, io_wr_i, io_rd_i, stall, slow;
    logic [7:0] io_addr_i, io_wdata_i, io_rdata_o, chreq, ack, tc;
    logic io_rvalid_o, xfer_valid_o, xfer_ready_i, xfer_last_o;
    logic [23:0] xfer_addr_o;
    logic [1:0] xfer_type_o;
    logic [2:0] xfer_chan_o;
    logic [23:0] q_addr[$];
    logic [2:0] q_chan[$];
    logic [1:0] q_type[$];
    logic q_last[$];
    int bad_count = 0;
    int samples_checked = 0;

    dcldma_top #(.FIFO_DEPTH(16)) dcldma_top_inst (.clk_sys_i, .arst_n_i,
        .cpu_reset_i, .io_addr_i, .io_wr_i, .io_rd_i, .io_wdata_i,
        .io_rdata_o, .io_rvalid_o, .channel_request_line_i(chreq),
        .channel_acknowledge_line_o(ack), .terminal_count_o(tc),
        .xfer_valid_o, .xfer_ready_i, .xfer_addr_o, .xfer_type_o,
        .xfer_chan_o, .xfer_last_o);
    dcldma_sink dcldma_sink_inst (.clk_sys_i, .arst_n_i, .stall_i(stall),
        .slow_i(slow), .ready_o(xfer_ready_i));

    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    always @(posedge clk_sys_i) begin
        if (xfer_valid_o && xfer_ready_i) begin
            q_addr.push_back(xfer_addr_o);
            q_chan.push_back(xfer_chan_o);
            q_type.push_back(xfer_type_o);
            q_last.push_back(xfer_last_o);
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    task automatic w(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        io_addr_i <= a;
        io_wdata_i <= d;
        io_wr_i <= 1'h1;
        @(posedge clk_sys_i);
        io_wr_i <= 1'h0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys_i);
        io_addr_i <= a;
        io_rd_i <= 1'h1;
        @(posedge clk_sys_i);
        io_rd_i <= 1'h0;
        #1;
        check({24'h0, io_rdata_o}, {24'h0, exp});
    endtask
    // Low byte first, pointer assumed cleared by the caller
    task automatic prog16(input logic [7:0] a, input logic [15:0] v);
        w(a, v[7:0]);
        w(a, v[15:8]);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    task automatic wait_pops(input int n);
        for (int i = 0; i < 400 && q_addr.size() < n; i++) idle(1);
    endtask
    task automatic qclr();
        q_addr.delete();
        q_chan.delete();
        q_type.delete();
        q_last.delete();
    endtask

    task automatic t_reset();
        rc(8'h08, 8'h00);
        rc(8'hde, 8'h0f);
        rc(8'h0b, 8'h00);
        rc(8'h40, 8'h00);
        w(8'hd6, 8'hc0);
        w(8'hdc, 8'h00);
        rc(8'hde, 8'h00);
    endtask
    task automatic t_fifo();
        int n;
        n = 0;
        stall <= 1'h1;
        w(8'h0c, 8'h00);
        prog16(8'h00, 16'h1234);
        prog16(8'h01, 16'h001f);
        w(8'h87, 8'h5a);
        w(8'h0b, 8'h44);
        w(8'h0e, 8'h00);
        chreq <= 8'h01;
        repeat (60) begin
            idle(1);
            if (ack[0] === 1'h1) n++;
        end
        check(n, 16);
        stall <= 1'h0;
        wait_pops(32);
        chreq <= 8'h00;
        check(q_addr.size(), 32);
        check(q_addr[0], 24'h5a1234);
        check(q_addr[31], 24'h5a1253);
        check({q_last[30], q_last[31]}, 2'h1);
        rc(8'h08, 8'h01);
        rc(8'h08, 8'h00);
        rc(8'h0f, 8'h01);
        w(8'h0c, 8'h00);
        rc(8'h00, 8'h54);
        rc(8'h00, 8'h12);
        rc(8'h01, 8'hff);
    endtask
    task automatic t_auto();
        qclr();
        slow <= 1'h1;
        w(8'h0c, 8'h00);
        prog16(8'h02, 16'h0010);
        prog16(8'h03, 16'h0001);
        w(8'h83, 8'h00);
        w(8'h0b, 8'h75);
        w(8'h0a, 8'h01);
        chreq <= 8'h02;
        for (int k = 0; k < 200 && tc[1] !== 1'h1; k++) idle(1);
        chreq <= 8'h00;
        idle(60);
        slow <= 1'h0;
        rc(8'h0f, 8'h01);
        check(q_last[1], 1'h1);
        foreach (q_addr[i]) begin
            check(q_addr[i], (i % 2) ? 24'h00000f : 24'h000010);
        end
    endtask
    task automatic t_sweep();
        for (int m = 0; m < 4; m++) begin
            for (int t = 0; t < 4; t++) begin
                qclr();
                w(8'h0c, 8'h00);
                prog16(8'h03, 16'h0000);
                w(8'h0b, {m[1:0], 2'h0, t[1:0], 2'h1});
                w(8'h0a, 8'h01);
                chreq <= 8'h02;
                idle(20);
                if (m == 3) check(ack[1], 1'h1);
                chreq <= 8'h00;
                check(q_addr.size(), (m == 3) ? 0 : 1);
                if (m != 3) check({q_chan[0], q_type[0]}, {3'h1, t[1:0]});
            end
        end
    endtask
    // Channel 7 stays masked: the software request must still run
    task automatic t_soft();
        qclr();
        w(8'hd8, 8'h00);
        prog16(8'hcc, 16'h0100);
        prog16(8'hce, 16'h0000);
        w(8'h8a, 8'h13);
        w(8'hd6, 8'h8b);
        w(8'hd4, 8'h07);
        w(8'hd0, 8'h04);
        w(8'hd2, 8'h07);
        idle(20);
        check(q_addr.size(), 0);
        rc(8'hd0, 8'h80);
        w(8'hd0, 8'h00);
        wait_pops(1);
        check(q_addr[0], 24'h120200);
        check({q_chan[0], q_type[0], q_last[0]}, {3'h7, 2'h2, 1'h1});
        rc(8'hd0, 8'h08);
    endtask
    task automatic t_prio();
        qclr();
        w(8'h0c, 8'h00);
        prog16(8'h05, 16'h0000);
        prog16(8'h07, 16'h0000);
        w(8'h0b, 8'h46);
        w(8'h0b, 8'h47);
        w(8'h0e, 8'h00);
        w(8'hd4, 8'h04);
        chreq <= 8'h0c;
        idle(20);
        check(q_addr.size(), 0);
        rc(8'hd0, 8'h10);
        rc(8'h08, 8'hc2);
        w(8'hde, 8'h00);
        wait_pops(2);
        chreq <= 8'h00;
        check({q_chan[0], q_chan[1]}, {3'h2, 3'h3});
        // Rotating order alternates where fixed would repeat channel 2
        w(8'h08, 8'h10);
        w(8'h0c, 8'h00);
        prog16(8'h05, 16'h0001);
        prog16(8'h07, 16'h0001);
        w(8'h0e, 8'h00);
        qclr();
        chreq <= 8'h0c;
        wait_pops(4);
        chreq <= 8'h00;
        check({q_chan[0], q_chan[1], q_chan[2], q_chan[3]}, 12'h4d3);
    endtask
    task automatic t_clear();
        w(8'h00, 8'haa);
        w(8'h0d, 8'h00);
        rc(8'h0f, 8'h0f);
        prog16(8'h00, 16'h2211);
        rc(8'h00, 8'h11);
        rc(8'h00, 8'h22);
        w(8'h00, 8'h33);
        idle(1);
        cpu_reset_i <= 1'h1;
        idle(1);
        cpu_reset_i <= 1'h0;
        rc(8'h0f, 8'h0f);
        rc(8'h00, 8'h33);
    endtask

    task automatic conclude();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        arst_n_i = 1'h0;
        cpu_reset_i = 1'h0;
        io_wr_i = 1'h0;
        io_rd_i = 1'h0;
        io_addr_i = 8'h00;
        io_wdata_i = 8'h00;
        chreq = 8'h00;
        stall = 1'h0;
        slow = 1'h0;
        idle(10);
        arst_n_i <= 1'h1;
        t_reset();
        t_fifo();
        t_auto();
        t_sweep();
        t_soft();
        t_prio();
        t_clear();
        conclude();
    end

    // Whole run needs under a thousand cycles
    initial begin
        #100us;
        bad_count++;
        conclude();
    end
endmodule // dcldma_top_test
